/* File: src/hbsrd_fifo.sv */
/*
  Receive FIFO with a registered output stage, valid/ready on both sides.
  Assumes DEPTH is a power of two; one clock, asynchronous active-high reset.
*/
`timescale 1ns/10ps
module hbsrd_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 8
) (
  input wire logic clk_in, // Core clock
  input wire logic rst_in, // Async reset, high
  input wire logic in_valid_in, // Write request
  input wire logic [W-1:0] in_data_in, // Write word
  output logic in_ready_out, // Room for a word
  output logic out_valid_out, // Output word held
  output logic [W-1:0] out_data_out, // Output word
  input wire logic out_ready_in // Drain accepts
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ov_q, ov_d;
  logic [W-1:0] od_q, od_d;
  logic push, load;

  // ----------------------------------------------------------------
  // Pointer and output stage next values
  // ----------------------------------------------------------------
  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = ov_q;
  assign out_data_out = od_q;
  assign push = in_valid_in && in_ready_out;
  // Refill the output register whenever storage holds a word and the register is empty or being taken
  assign load = (cnt_q != '0) && (!ov_q || out_ready_in);

  always_comb
  begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = load ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
    ov_d = load ? 1'b1 : (out_ready_in ? 1'b0 : ov_q);
    od_d = load ? mem_q[rd_q] : od_q;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end

  // Storage needs no reset; it is never read before written
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_q[wr_q] <= in_data_in;
  end
endmodule

/* File: src/hbsrd_pkg.sv */
/*
  Shared constants and types for the host bus snoop, response and data block.
  Assumes a single core clock; all link pins are sampled by that clock.
*/
package hbsrd_pkg;
  // ----------------------------------------------------------------
  // Data path geometry
  // ----------------------------------------------------------------
  localparam int GRP_W = 16; // Bits per strobe group
  localparam int GRP_N = 4; // Strobe groups on the bus
  localparam int DATA_W = GRP_W * GRP_N; // Full data word
  localparam int DBI_MAX_LOW = 8; // Most pins low per group
  localparam int FIFO_DEPTH = 8; // Receive buffer words
  localparam int STRAP_W = 3; // Bus speed strap width
  localparam logic [1:0] STRAP_SETTLE = 2'h2; // Edges until strap sync is full

  // ----------------------------------------------------------------
  // Response encodings, logical (pins carry the inverse)
  // ----------------------------------------------------------------
  localparam logic [2:0] RESP_IDLE = 3'h0;
  localparam logic [2:0] RESP_RETRY = 3'h1;
  localparam logic [2:0] RESP_DEFER = 3'h2;
  localparam logic [2:0] RESP_RSVD = 3'h3;
  localparam logic [2:0] RESP_HARD = 3'h4;
  localparam logic [2:0] RESP_NODATA = 3'h5;
  localparam logic [2:0] RESP_IWB = 3'h6;
  localparam logic [2:0] RESP_NORMAL = 3'h7;

  // ----------------------------------------------------------------
  // Transmit sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_SETUP, TX_FALL, TX_RISE} hbsrd_tx_state_type;
endpackage

/* File: src/hbsrd_top.sv */
/*
  Host bus data strobes, bus inversion, snoop result, target ready, response
  code, defer and bus speed strap logic of the memory controller's host port.
  Assumes all link pins are asynchronous to CLK_IN and are slower than it;
  pin levels are resolved from the output enables outside this module.
*/
// Summary of operation
// - Bus owner strobes each data group
// - Four groups, each timed by own strobe
// - Capture on falling edge of either strobe
// - Clean hit reports unmodified cached line
// - Dirty hit reports modified line, supplies it
// - Both hits together extend snoop window
// - Target ready only when transfer possible
// - Response codes encoded as three-bit table
// - Never drive reserved or hard-failure codes
// - Bus speed strap sampled at reset release
// - Inversion keeps at most eight low pins
// - Defer during snoop of deferred/retried transaction
`timescale 1ns/10ps
module hbsrd_top (
  input wire logic CLK_IN, // Core clock, 20 MHz
  input wire logic SYS_RST_IN, // Async reset, high
  input wire logic [hbsrd_pkg::GRP_N-1:0] DATA_STROBE_TRUE_N_IN, // Strobe pin level
  output logic [hbsrd_pkg::GRP_N-1:0] DATA_STROBE_TRUE_N_OUT, // Strobe drive
  input wire logic [hbsrd_pkg::GRP_N-1:0] DATA_STROBE_COMP_N_IN, // Comp strobe level
  output logic [hbsrd_pkg::GRP_N-1:0] DATA_STROBE_COMP_N_OUT, // Comp strobe drive
  output logic DATA_STROBE_OE_OUT, // Strobe enable
  input wire logic [hbsrd_pkg::DATA_W-1:0] HOST_DATA_LINES_N_IN, // Data pin level
  output logic [hbsrd_pkg::DATA_W-1:0] HOST_DATA_LINES_N_OUT, // Data drive
  input wire logic [hbsrd_pkg::GRP_N-1:0] DATA_GROUP_INVERT_N_IN, // Inversion level
  output logic [hbsrd_pkg::GRP_N-1:0] DATA_GROUP_INVERT_N_OUT, // Inversion drive
  output logic HOST_DATA_OE_OUT, // Data and inversion enable
  input wire logic SNOOP_CLEAN_HIT_N_IN, // Clean hit level
  output logic SNOOP_CLEAN_HIT_N_OUT, // Clean hit drive
  input wire logic SNOOP_DIRTY_HIT_N_IN, // Dirty hit level
  output logic SNOOP_DIRTY_HIT_N_OUT, // Dirty hit drive
  output logic SNOOP_HIT_OE_OUT, // Hit pins enable
  output logic TARGET_DATA_READY_N_OUT, // Target ready, low
  output logic [2:0] RESPONSE_CODE_N_OUT, // Response, inverted code
  output logic DEFER_INDICATOR_N_OUT, // Defer, low
  input wire logic [hbsrd_pkg::STRAP_W-1:0] BUS_SPEED_STRAP_IN, // Speed strap pins
  output logic [hbsrd_pkg::STRAP_W-1:0] BUS_SPEED_OUT, // Latched speed select
  output logic [hbsrd_pkg::DATA_W-1:0] RX_DATA_OUT, // Received word
  output logic RX_VALID_OUT, // Received word valid
  input wire logic RX_READY_IN, // Core takes word
  input wire logic [hbsrd_pkg::DATA_W-1:0] TX_DATA_IN, // Word to send
  input wire logic TX_VALID_IN, // Send request
  output logic TX_READY_OUT, // Sender idle
  input wire logic TRDY_REQ_IN, // Core wants data phase
  input wire logic SNOOP_STROBE_IN, // Snoop phase, one cycle
  input wire logic [1:0] SNOOP_RESULT_IN, // {dirty, clean} own hit
  input wire logic SNOOP_EXTEND_IN, // Need more snoop time
  input wire logic [2:0] RESP_PLAN_IN, // Planned response code
  input wire logic RESP_VALID_IN, // Drive response, one cycle
  input wire logic [2:0] RESP_CODE_IN, // Response code
  output logic [1:0] SNOOP_SEEN_OUT, // {dirty, clean} seen on bus
  output logic SNOOP_STALL_OUT // Bus asks for snoop stall
);
  import hbsrd_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [GRP_N-1:0] stbt_s1, stbt_s2, stbt_s3, stbc_s1, stbc_s2, stbc_s3;
  logic [DATA_W-1:0] dat_s1, dat_s2;
  logic [GRP_N-1:0] inv_s1, inv_s2;
  logic [1:0] hit_s1, hit_s2;
  logic [STRAP_W-1:0] strap_s1, strap_s2;

  // Data take two stages and strobes three; s3 only serves edge detection, so an edge seen at s2/s3 pairs with dat_s2
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      {stbt_s1, stbt_s2, stbt_s3, stbc_s1, stbc_s2, stbc_s3} <= '1;
      {dat_s1, dat_s2, inv_s1, inv_s2, hit_s1, hit_s2} <= '1;
      {strap_s1, strap_s2} <= '0;
    end
    else
    begin
      {stbt_s1, stbt_s2, stbt_s3} <= {DATA_STROBE_TRUE_N_IN, stbt_s1, stbt_s2};
      {stbc_s1, stbc_s2, stbc_s3} <= {DATA_STROBE_COMP_N_IN, stbc_s1, stbc_s2};
      {dat_s1, dat_s2} <= {HOST_DATA_LINES_N_IN, dat_s1};
      {inv_s1, inv_s2} <= {DATA_GROUP_INVERT_N_IN, inv_s1};
      {hit_s1, hit_s2} <= {{SNOOP_DIRTY_HIT_N_IN, SNOOP_CLEAN_HIT_N_IN}, hit_s1};
      {strap_s1, strap_s2} <= {BUS_SPEED_STRAP_IN, strap_s1};
    end
  end

  // ----------------------------------------------------------------
  // Receive capture, one lane per strobe group
  // ----------------------------------------------------------------
  logic [GRP_N-1:0][GRP_W-1:0] grp_data_q, grp_data_d;
  logic [GRP_N-1:0] grp_full_q, grp_full_d, rx_edge;
  logic fifo_in_ready, push, tx_busy;

  // Falling edges only; levels are meaningless between transfers
  assign rx_edge = (stbt_s3 & ~stbt_s2) | (stbc_s3 & ~stbc_s2);
  assign push = (&grp_full_q) && fifo_in_ready;

  always_comb
  begin
    grp_data_d = grp_data_q;
    grp_full_d = push ? '0 : grp_full_q;
    for (int g = 0; g < GRP_N; g++)
    begin
      // Own transmissions are not looped back; a new edge wins over the push clear
      if (rx_edge[g] && !tx_busy)
      begin
        grp_data_d[g] = dat_s2[g*GRP_W +: GRP_W] ^ {GRP_W{inv_s2[g]}};
        grp_full_d[g] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      grp_data_q <= '0;
      grp_full_q <= '0;
    end
    else
    begin
      grp_data_q <= grp_data_d;
      grp_full_q <= grp_full_d;
    end
  end

  hbsrd_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .in_valid_in(&grp_full_q),
    .in_data_in(grp_data_q),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(RX_VALID_OUT),
    .out_data_out(RX_DATA_OUT),
    .out_ready_in(RX_READY_IN)
  );

  // ----------------------------------------------------------------
  // Transmit sequencer with bus inversion
  // ----------------------------------------------------------------
  // Pins carry inverted data; invert again when too many would go low
  function automatic logic [GRP_N+DATA_W-1:0] dbi_enc(input logic [DATA_W-1:0] w);
    logic [GRP_N-1:0] inv;
    logic [DATA_W-1:0] pin;
    int ones;
    inv = '1;
    pin = ~w;
    for (int g = 0; g < GRP_N; g++)
    begin
      ones = 0;
      for (int b = 0; b < GRP_W; b++)
        ones += int'(w[g*GRP_W+b]);
      if (ones > DBI_MAX_LOW)
      begin
        pin[g*GRP_W +: GRP_W] = w[g*GRP_W +: GRP_W];
        inv[g] = 1'b0;
      end
    end
    return {inv, pin};
  endfunction

  hbsrd_tx_state_type tx_state_q, tx_state_d;
  logic [DATA_W-1:0] dat_out_q, dat_out_d;
  logic [GRP_N-1:0] inv_out_q, inv_out_d, stbt_q, stbt_d, stbc_q, stbc_d;
  logic oe_q, oe_d, phase_q, phase_d, txr_q, txr_d, tx_tail_q, tx_tail_d;

  // Own strobe edge reaches the edge detector in the first idle cycle, so mask one cycle longer
  assign tx_busy = (tx_state_q != TX_IDLE) || tx_tail_q;

  always_comb
  begin
    tx_state_d = tx_state_q;
    {dat_out_d, inv_out_d} = {dat_out_q, inv_out_q};
    {stbt_d, stbc_d} = '1;
    {oe_d, phase_d, txr_d} = {oe_q, phase_q, txr_q};
    tx_tail_d = (tx_state_q != TX_IDLE);
    case (tx_state_q)
      TX_IDLE:
        if (TX_VALID_IN && txr_q)
        begin
          {inv_out_d, dat_out_d} = dbi_enc(TX_DATA_IN);
          {oe_d, txr_d} = 2'h2;
          tx_state_d = TX_SETUP;
        end
      TX_SETUP:
      begin
        // Pair members take turns, so every transfer is a falling edge
        if (phase_q)
          stbc_d = '0;
        else
          stbt_d = '0;
        tx_state_d = TX_FALL;
      end
      TX_FALL:
        tx_state_d = TX_RISE;
      TX_RISE:
      begin
        {oe_d, txr_d} = 2'h1;
        phase_d = ~phase_q;
        tx_state_d = TX_IDLE;
      end
      default:
        tx_state_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      tx_state_q <= TX_IDLE;
      {dat_out_q, inv_out_q} <= '1;
      {stbt_q, stbc_q} <= '1;
      {oe_q, phase_q, txr_q} <= 3'h1;
      tx_tail_q <= 1'b0;
    end
    else
    begin
      tx_state_q <= tx_state_d;
      {dat_out_q, inv_out_q} <= {dat_out_d, inv_out_d};
      {stbt_q, stbc_q} <= {stbt_d, stbc_d};
      {oe_q, phase_q, txr_q} <= {oe_d, phase_d, txr_d};
      tx_tail_q <= tx_tail_d;
    end
  end

  assign HOST_DATA_LINES_N_OUT = dat_out_q;
  assign DATA_GROUP_INVERT_N_OUT = inv_out_q;
  assign HOST_DATA_OE_OUT = oe_q;
  assign DATA_STROBE_OE_OUT = oe_q;
  assign DATA_STROBE_TRUE_N_OUT = stbt_q;
  assign DATA_STROBE_COMP_N_OUT = stbc_q;
  assign TX_READY_OUT = txr_q;

  // ----------------------------------------------------------------
  // Snoop, target ready, response, defer and strap
  // ----------------------------------------------------------------
  logic [1:0] hit_n_q, hit_n_d, seen_q, seen_d;
  logic hoe_q, hoe_d, stall_q, stall_d, trdy_n_q, trdy_n_d, defer_n_q, defer_n_d;
  logic [2:0] resp_n_q, resp_n_d;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic [STRAP_W-1:0] speed_q, speed_d;
  logic resp_bad, plan_defer;

  assign resp_bad = (RESP_CODE_IN == RESP_RSVD) || (RESP_CODE_IN == RESP_HARD);
  assign plan_defer = (RESP_PLAN_IN == RESP_DEFER) || (RESP_PLAN_IN == RESP_RETRY);

  always_comb
  begin
    hoe_d = SNOOP_STROBE_IN;
    hit_n_d = '1;
    defer_n_d = 1'b1;
    if (SNOOP_STROBE_IN)
    begin
      hit_n_d[0] = ~(SNOOP_RESULT_IN[0] | SNOOP_EXTEND_IN);
      hit_n_d[1] = ~(SNOOP_RESULT_IN[1] | SNOOP_EXTEND_IN);
      defer_n_d = ~plan_defer;
    end
    seen_d = ~hit_s2;
    stall_d = (hit_s2 == 2'h0);
    // Only offer the data phase while a whole word fits in the buffer
    trdy_n_d = ~(TRDY_REQ_IN && fifo_in_ready);
    // Illegal codes collapse to idle rather than reaching the bus
    resp_n_d = ~((RESP_VALID_IN && !resp_bad) ? RESP_CODE_IN : RESP_IDLE);
    strap_cnt_d = (strap_cnt_q == STRAP_SETTLE + 2'h1) ? strap_cnt_q : strap_cnt_q + 2'h1;
    speed_d = (strap_cnt_q == STRAP_SETTLE) ? strap_s2 : speed_q;
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      {hit_n_q, seen_q, hoe_q, stall_q} <= 6'h30;
      {trdy_n_q, defer_n_q, resp_n_q} <= '1;
      strap_cnt_q <= '0;
      speed_q <= '0;
    end
    else
    begin
      {hit_n_q, seen_q, hoe_q, stall_q} <= {hit_n_d, seen_d, hoe_d, stall_d};
      {trdy_n_q, defer_n_q, resp_n_q} <= {trdy_n_d, defer_n_d, resp_n_d};
      strap_cnt_q <= strap_cnt_d;
      speed_q <= speed_d;
    end
  end

  assign {SNOOP_DIRTY_HIT_N_OUT, SNOOP_CLEAN_HIT_N_OUT} = hit_n_q;
  assign SNOOP_HIT_OE_OUT = hoe_q;
  assign SNOOP_SEEN_OUT = seen_q;
  assign SNOOP_STALL_OUT = stall_q;
  assign TARGET_DATA_READY_N_OUT = trdy_n_q;
  assign DEFER_INDICATOR_N_OUT = defer_n_q;
  assign RESPONSE_CODE_N_OUT = resp_n_q;
  assign BUS_SPEED_OUT = speed_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  function automatic logic dbi_ok(input logic [DATA_W-1:0] p);
    logic ok;
    ok = 1'b1;
    for (int g = 0; g < GRP_N; g++)
      if ($countones(~p[g*GRP_W +: GRP_W]) > DBI_MAX_LOW)
        ok = 1'b0;
    return ok;
  endfunction

  sequence strobe_low_s;
    (stbt_q == '0) || (stbc_q == '0);
  endsequence
  sequence strobe_high_s;
    (stbt_q == '1) && (stbc_q == '1) && oe_q;
  endsequence

  strobe_pulse_a: assert property (tx_state_q == TX_SETUP |=> strobe_low_s ##1 strobe_high_s)
    else $error("strobe pulse missing");
  capture_edge_a: assert property (rx_edge[0] && !tx_busy |=> grp_full_q[0])
    else $error("group edge not captured");
  dbi_limit_a: assert property (oe_q |-> dbi_ok(dat_out_q))
    else $error("too many data pins low");
  snoop_extend_a: assert property (SNOOP_STROBE_IN && SNOOP_EXTEND_IN |=> hoe_q && hit_n_q == 2'h0)
    else $error("snoop extend not driven");
  trdy_room_a: assert property (!TARGET_DATA_READY_N_OUT |-> $past(TRDY_REQ_IN) && $past(fifo_in_ready))
    else $error("target ready without room");
  resp_map_a: assert property (RESP_VALID_IN && !resp_bad |=> RESPONSE_CODE_N_OUT == ~$past(RESP_CODE_IN))
    else $error("response code mismatch");
  resp_legal_a: assert property (RESPONSE_CODE_N_OUT != ~RESP_RSVD && RESPONSE_CODE_N_OUT != ~RESP_HARD)
    else $error("illegal response driven");
  defer_snoop_a: assert property (!DEFER_INDICATOR_N_OUT |-> $past(SNOOP_STROBE_IN) && $past(plan_defer))
    else $error("defer outside snoop");
  strap_hold_a: assert property (strap_cnt_q == STRAP_SETTLE |=> BUS_SPEED_OUT == $past(strap_s2) ##1 $stable(BUS_SPEED_OUT)[*3])
    else $error("bus speed strap not held");
endmodule

/* File: testbench/hbsrd_cpu_model.sv */
/*
  Processor-side model of the data, inversion, strobe and hit pins.
  Assumes wired-low pins with pull-ups: an undriven output stands at 1.
*/
`timescale 1ns/10ps
module hbsrd_cpu_model (
  input wire logic dut_oe_in, // Device drives data
  input wire logic [3:0] stb_t_in, // True strobe pins
  input wire logic [3:0] stb_c_in, // Comp strobe pins
  input wire logic [63:0] data_in, // Data pins
  input wire logic [3:0] inv_in, // Inversion pins
  output logic [3:0] stb_t_out, // True strobe drive
  output logic [3:0] stb_c_out, // Comp strobe drive
  output logic [63:0] data_out, // Data drive
  output logic [3:0] inv_out, // Inversion drive
  output logic clean_n_out, // Clean hit drive
  output logic dirty_n_out, // Dirty hit drive
  output logic [63:0] got_out, // Last word taken
  output logic [7:0] got_cnt_out, // Words taken
  output logic [4:0] max_low_out // Most low pins
);
  logic use_comp;
  // All pins released at start
  initial
  begin
    use_comp = 1'b0;
    {stb_t_out, stb_c_out, inv_out, clean_n_out, dirty_n_out} = '1;
    data_out = '1;
    got_out = '0;
    got_cnt_out = 8'h00;
    max_low_out = 5'h00;
  end
  // One word per frame; link strobe only moves inside it
  task automatic send_word(input logic [63:0] w, input int gap);
    logic [15:0] g;
    #13;
    for (int i = 0; i < 4; i++)
    begin
      g = w[16*i +: 16];
      inv_out[i] = ($countones(g) <= 8);
      data_out[16*i +: 16] = ($countones(g) > 8) ? g : ~g;
    end
    #100;
    if (use_comp)
      stb_c_out = 4'h0;
    else
      stb_t_out = 4'h0;
    #200;
    {stb_t_out, stb_c_out} = '1;
    use_comp = !use_comp;
    #100;
    // Released lines go to the pull-up level
    data_out = '1;
    inv_out = 4'hF;
    #(gap);
  endtask
  // Hit pins are wired, both low asks for more time
  task automatic set_hits(input logic c, input logic d);
    clean_n_out <= !c;
    dirty_n_out <= !d;
  endtask
  // Takes device words on a fall of either strobe
  always @(negedge stb_t_in[0] or negedge stb_c_in[0])
  begin
    if (dut_oe_in)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (5'(16 - $countones(data_in[16*i +: 16])) > max_low_out)
          max_low_out = 5'(16 - $countones(data_in[16*i +: 16]));
        got_out[16*i +: 16] = inv_in[i] ? ~data_in[16*i +: 16] : data_in[16*i +: 16];
      end
      got_cnt_out = got_cnt_out + 8'h01;
    end
  end
endmodule

/* File: testbench/hbsrd_top_tb.sv */
/*
  Self-checking bench for the host bus snoop, response and data block.
  Assumes the processor model is compiled first; pins pulled up.
*/
`timescale 1ns/10ps
module hbsrd_top_tb;
  import hbsrd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] strap = 3'h5;
  logic rx_rdy = 1'b0;
  logic [63:0] tx_d = 64'h0;
  logic tx_v = 1'b0;
  logic trdy_req = 1'b0;
  logic snp = 1'b0;
  logic [1:0] snp_res = 2'h0;
  logic snp_ext = 1'b0;
  logic [2:0] plan = 3'h0;
  logic rsp_v = 1'b0;
  logic [2:0] rsp_c = 3'h0;
  logic [3:0] d_st_t, d_st_c, m_st_t, m_st_c, d_inv, m_inv;
  logic [63:0] d_dat, m_dat, got, rx_d;
  logic st_oe, dat_oe, hit_oe, d_cl, d_dt, m_cl, m_dt, trdy_n, defer_n, tx_rdy, rx_v, stall;
  logic [2:0] rsp_n, speed;
  logic [1:0] seen;
  logic [7:0] got_cnt;
  logic [4:0] max_low;
  int failures = 0;
  int checks = 0;
  // Wired-low pins: nobody driving means high
  wire logic [3:0] p_st_t = (st_oe ? d_st_t : 4'hF) & m_st_t;
  wire logic [3:0] p_st_c = (st_oe ? d_st_c : 4'hF) & m_st_c;
  wire logic [63:0] p_dat = (dat_oe ? d_dat : '1) & m_dat;
  wire logic [3:0] p_inv = (dat_oe ? d_inv : 4'hF) & m_inv;
  wire logic p_cl = (hit_oe ? d_cl : 1'b1) & m_cl;
  wire logic p_dt = (hit_oe ? d_dt : 1'b1) & m_dt;
  always #25 clk = ~clk;
  hbsrd_top dut (.CLK_IN(clk), .SYS_RST_IN(rst),
    .DATA_STROBE_TRUE_N_IN(p_st_t), .DATA_STROBE_TRUE_N_OUT(d_st_t),
    .DATA_STROBE_COMP_N_IN(p_st_c), .DATA_STROBE_COMP_N_OUT(d_st_c), .DATA_STROBE_OE_OUT(st_oe),
    .HOST_DATA_LINES_N_IN(p_dat), .HOST_DATA_LINES_N_OUT(d_dat), .DATA_GROUP_INVERT_N_IN(p_inv),
    .DATA_GROUP_INVERT_N_OUT(d_inv), .HOST_DATA_OE_OUT(dat_oe), .SNOOP_CLEAN_HIT_N_IN(p_cl),
    .SNOOP_CLEAN_HIT_N_OUT(d_cl), .SNOOP_DIRTY_HIT_N_IN(p_dt), .SNOOP_DIRTY_HIT_N_OUT(d_dt),
    .SNOOP_HIT_OE_OUT(hit_oe), .TARGET_DATA_READY_N_OUT(trdy_n), .RESPONSE_CODE_N_OUT(rsp_n),
    .DEFER_INDICATOR_N_OUT(defer_n), .BUS_SPEED_STRAP_IN(strap), .BUS_SPEED_OUT(speed),
    .RX_DATA_OUT(rx_d), .RX_VALID_OUT(rx_v), .RX_READY_IN(rx_rdy), .TX_DATA_IN(tx_d),
    .TX_VALID_IN(tx_v), .TX_READY_OUT(tx_rdy), .TRDY_REQ_IN(trdy_req), .SNOOP_STROBE_IN(snp),
    .SNOOP_RESULT_IN(snp_res), .SNOOP_EXTEND_IN(snp_ext), .RESP_PLAN_IN(plan),
    .RESP_VALID_IN(rsp_v), .RESP_CODE_IN(rsp_c), .SNOOP_SEEN_OUT(seen), .SNOOP_STALL_OUT(stall));
  hbsrd_cpu_model cpu (.dut_oe_in(dat_oe), .stb_t_in(p_st_t), .stb_c_in(p_st_c),
    .data_in(p_dat), .inv_in(p_inv), .stb_t_out(m_st_t), .stb_c_out(m_st_c), .data_out(m_dat),
    .inv_out(m_inv), .clean_n_out(m_cl), .dirty_n_out(m_dt), .got_out(got),
    .got_cnt_out(got_cnt), .max_low_out(max_low));
  // ------
  // Shared helpers
  // ------
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] obs);
    checks++;
    if (obs !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, obs);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  // Idle outputs in reset, strap latched once at release
  task automatic t_reset_strap();
    check("response", 3'h7, rsp_n);
    check("trdy", 1, trdy_n);
    check("defer", 1, defer_n);
    @(posedge clk) rst <= 1'b0;
    repeat (5) @(posedge clk);
    strap <= 3'h2;
    repeat (5) @(negedge clk);
    check("speed", 3'h5, speed);
    $display("test reset_strap done");
  endtask
  // Every hit result and planned response in turn
  task automatic t_snoop_drive();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      snp <= 1'b1;
      snp_res <= i[1:0];
      snp_ext <= i[2];
      plan <= i[2:0];
      @(posedge clk) snp <= 1'b0;
      @(negedge clk);
      check("hit oe", 1, hit_oe);
      check("clean", !(i[0] | i[2]), d_cl);
      check("dirty", !(i[1] | i[2]), d_dt);
      check("defer", !(i == 1 || i == 2), defer_n);
      @(negedge clk);
      check("hit oe end", 0, hit_oe);
    end
    $display("test snoop_drive done");
  endtask
  // Hits driven by the processor are reported
  task automatic t_snoop_seen();
    for (int k = 1; k < 4; k++)
    begin
      cpu.set_hits(k[0], k[1]);
      repeat (5) @(negedge clk);
      check("seen", k[1:0], seen);
      check("stall", k == 3, stall);
      cpu.set_hits(1'b0, 1'b0);
      repeat (5) @(negedge clk);
    end
    $display("test snoop_seen done");
  endtask
  // All codes back to back; two must never reach the pins
  task automatic t_response();
    @(posedge clk);
    rsp_v <= 1'b1;
    rsp_c <= 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      if (i < 7)
        rsp_c <= 3'(i + 1);
      else
        rsp_v <= 1'b0;
      @(negedge clk);
      check("resp", (i == 3 || i == 4) ? 3'h7 : 3'(~i), rsp_n);
    end
    @(negedge clk);
    check("resp idle", 3'h7, rsp_n);
    $display("test response done");
  endtask
  // Fill the buffer until ready drops, core stalled, then drain
  task automatic t_receive();
    logic [63:0] exp [$];
    int n;
    int k;
    n = 0;
    k = 0;
    @(posedge clk) trdy_req <= 1'b1;
    repeat (2) @(negedge clk);
    check("trdy low", 0, trdy_n);
    while (n < 12 && trdy_n === 1'b0)
    begin
      exp.push_back(64'hFFFF_0000_F0F1_0E00 + n * 64'h1111_1111_1111_1111);
      cpu.send_word(exp[n], (n % 2) * 400);
      n++;
      repeat (2) @(negedge clk);
    end
    check("fill", 1, n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1);
    check("trdy full", 1, trdy_n);
    @(posedge clk) rx_rdy <= 1'b1;
    for (int t = 0; t < 40 && k < n; t++)
    begin
      @(negedge clk);
      if (rx_v === 1'b1)
      begin
        check("rx word", exp[k], rx_d);
        k++;
      end
    end
    check("drained", n, k);
    check("trdy again", 0, trdy_n);
    $display("test receive done");
  endtask
  // Two words out, one per strobe of the pair
  task automatic t_transmit();
    logic [63:0] w [2] = '{64'hFFFE_0001_A5A5_7FFF, 64'h0000_FFFF_1234_8000};
    @(posedge clk) rx_rdy <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      tx_v <= 1'b1;
      tx_d <= w[i];
      @(negedge clk);
      for (int t = 0; t < 20 && tx_rdy !== 1'b1; t++)
        @(negedge clk);
      @(posedge clk) tx_v <= 1'b0;
      repeat (6) @(negedge clk);
      check("tx word", w[i], got);
      check("tx count", i + 1, got_cnt);
      check("low pins ok", 1, max_low <= 8);
    end
    // Own strobes must not come back as a received word
    repeat (4) @(negedge clk);
    check("no loopback", 0, rx_v);
    $display("test transmit done");
  endtask
  // Watchdog far beyond the expected run of roughly a dozen microseconds
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    t_reset_strap();
    t_snoop_drive();
    t_snoop_seen();
    t_response();
    t_receive();
    t_transmit();
    report_and_stop();
  end
endmodule
